// ===== verilog/gpib_resp_pkg.sv
// Shared constants for the bus command responder and its bus controller
// ****************************************************************
// ****************************************************************
package gpib_resp_pkg;
    // ************************************************************
    // Bus command bytes
    // ************************************************************
    localparam logic [7:0] CMD_GTL = 8'h01;
    localparam logic [7:0] CMD_SDC = 8'h04;
    localparam logic [7:0] CMD_GET = 8'h08;
    localparam logic [7:0] CMD_LLO = 8'h11;
    localparam logic [7:0] CMD_DCL = 8'h14;
    localparam logic [7:0] CMD_SPE = 8'h18;
    localparam logic [7:0] CMD_SPD = 8'h19;
    localparam logic [7:0] CMD_UNL = 8'h3F;
    localparam logic [7:0] CMD_UNT = 8'h5F;
    // Address group field, bits 6:5, and address field, bits 4:0
    localparam int GRP_MSB = 6;
    localparam int GRP_LSB = 5;
    localparam int ADR_MSB = 4;
    localparam logic [1:0] GRP_LISTEN = 2'h1;
    localparam logic [1:0] GRP_TALK = 2'h2;
    // ************************************************************
    // Modes and default state
    // ************************************************************
    localparam logic [1:0] PROG_STEP = 2'h0;
    localparam logic [1:0] PROG_SINGLE = 2'h1;
    localparam logic [1:0] CONTINUOUS_PROGRAM_MODE = 2'h2;
    localparam logic [2:0] START_ON_TRIGGER_MODE = 3'h2;
    localparam logic [2:0] STOP_ON_TRIGGER_MODE = 3'h3;
    localparam logic [2:0] TRIG_DEF = 3'h6;
    localparam logic [3:0] IO_PORT_DEF = 4'h0;
    localparam logic [23:0] ALARM_DEF = 24'h000000;
    localparam logic [16:0] INTERVAL_DEF_MS = 17'h02710;
    localparam logic [15:0] SETTLE_DEF_MS = 16'h0005;
    localparam logic EOI_DEF = 1'b1;
    localparam logic SRQ_DEF = 1'b0;
    localparam logic [4:0] PREFIX_DEF = 5'h00;
    localparam logic [7:0] PTR_FIRST = 8'h01;
    localparam logic [7:0] STATUS_DEF = 8'h00;
    // ************************************************************
    // Controller orders and software registers
    // ************************************************************
    localparam logic [2:0] OP_CMD = 3'h0;
    localparam logic [2:0] OP_ADDR = 3'h1;
    localparam logic [2:0] OP_DATA = 3'h2;
    localparam logic [2:0] OP_REN_ON = 3'h3;
    localparam logic [2:0] OP_REN_OFF = 3'h4;
    localparam logic [2:0] OP_POLL = 3'h5;
    localparam logic [1:0] K_CMD = 2'h0;
    localparam logic [1:0] K_DATA = 2'h1;
    localparam logic [1:0] K_READ = 2'h2;
    localparam logic [1:0] REG_CMD = 2'h0;
    localparam logic [1:0] REG_STAT = 2'h1;
    localparam int F_BYTE_LSB = 0;
    localparam int F_ADDR_LSB = 8;
    localparam int F_OP_LSB = 13;
    localparam logic [1:0] POLL_WAIT = 2'h2;
endpackage

// ===== verilog/gpib_link_if.sv
// Bus wires between the controller and the responder
`timescale 1ns/1ps
interface gpib_link_if (
    input wire logic clk
);
    logic [7:0] ctl_dio_n; // Controller data, low true
    logic ctl_dio_oe; // Controller drives data
    logic [7:0] dev_dio_n; // Responder data, low true
    logic dev_dio_oe; // Responder drives data
    logic atn_n; // Attention, low true
    logic ren_n; // Remote enable, low true
    logic stb; // One-cycle byte strobe
    logic [7:0] dio_n; // Resolved open-collector data
    // Undriven lines float high; any driver pulls low
    assign dio_n = (ctl_dio_oe ? ctl_dio_n : 8'hFF) & (dev_dio_oe ? dev_dio_n : 8'hFF);
    modport dev (input atn_n, input ren_n, input stb, input dio_n,
                 output dev_dio_n, output dev_dio_oe);
    modport ctl (output atn_n, output ren_n, output stb, output ctl_dio_n,
                 output ctl_dio_oe, input dio_n);
endinterface

// ===== verilog/gpib_bus_command_responder.sv
// Instrument end: decodes bus commands and holds the default state
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
module gpib_bus_command_responder
    import gpib_resp_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Bus side
    gpib_link_if.dev link,
    // Configuration and scan engine
    input wire logic [4:0] my_addr_in,
    input wire logic status_wr_in,
    input wire logic [7:0] status_in,
    input wire logic mode_wr_in,
    input wire logic [1:0] prog_mode_in,
    input wire logic [2:0] trig_mode_in,
    // Front panel
    input wire logic [15:0] panel_keys_in,
    output logic [15:0] panel_keys_out,
    output logic lockout_out,
    output logic remote_out,
    // Addressing state
    output logic talk_out,
    output logic listen_out,
    output logic spoll_out,
    // Device-dependent data bytes
    output logic ddc_valid_out,
    output logic [7:0] ddc_byte_out,
    // Default state
    output logic clear_out,
    output logic [7:0] buf_ptr_out,
    output logic [7:0] disp_ptr_out,
    output logic [1:0] prog_mode_out,
    output logic [2:0] trig_mode_out,
    output logic [3:0] io_port_out,
    output logic [23:0] alarm_time_out,
    output logic alarm_en_out,
    output logic [16:0] interval_out,
    output logic [15:0] settle_out,
    output logic eoi_en_out,
    output logic srq_en_out,
    output logic [4:0] prefix_out,
    output logic run_out
);
    // ************************************************************
    // Decode
    // ************************************************************
    logic [7:0] rx; // Received byte, positive logic
    logic atn; // Attention asserted
    logic ren; // Remote enable asserted
    logic cmd_stb; // Command byte strobe
    logic dat_stb; // Data byte strobe
    logic adr_me; // Address field matches ours
    logic grp_listen; // Listen address group
    logic grp_talk; // Talk address group
    logic listen_r;
    logic talk_r;
    logic spoll_r;
    logic drive_r; // Status byte drive armed
    logic lockout_r;
    logic remote_r;
    logic [7:0] status_r;
    logic clr; // Device clear or selected clear
    logic get_hit; // Trigger to us
    logic gtl_hit; // Go to local to us

    assign rx = ~link.dio_n;
    assign atn = ~link.atn_n;
    assign ren = ~link.ren_n;
    assign cmd_stb = link.stb & atn;
    assign dat_stb = link.stb & ~atn;
    assign adr_me = rx[ADR_MSB:0] == my_addr_in;
    assign grp_listen = rx[GRP_MSB:GRP_LSB] == GRP_LISTEN;
    assign grp_talk = rx[GRP_MSB:GRP_LSB] == GRP_TALK;
    // Addressed commands only while listen-addressed to our address
    assign clr = cmd_stb & ((rx == CMD_DCL) | (listen_r & rx == CMD_SDC));
    assign get_hit = cmd_stb & listen_r & (rx == CMD_GET);
    assign gtl_hit = cmd_stb & listen_r & (rx == CMD_GTL);

    // ************************************************************
    // Addressing state
    // ************************************************************
    // Listener: unlisten drops, our listen address takes
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            listen_r <= 1'b0;
        end else if (cmd_stb && rx == CMD_UNL) begin
            listen_r <= 1'b0;
        end else if (cmd_stb && grp_listen && adr_me) begin
            listen_r <= 1'b1;
        end
    end

    // Talker: untalk or another talk address drops
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            talk_r <= 1'b0;
        end else if (cmd_stb && rx == CMD_UNT) begin
            talk_r <= 1'b0;
        end else if (cmd_stb && grp_talk) begin
            talk_r <= adr_me;
        end
    end

    // Serial poll mode
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            spoll_r <= 1'b0;
        end else if (cmd_stb && rx == CMD_SPE) begin
            spoll_r <= 1'b1;
        end else if (cmd_stb && rx == CMD_SPD) begin
            spoll_r <= 1'b0;
        end
    end

    // ************************************************************
    // Remote and lockout
    // ************************************************************
    // Lockout needs remote enable and ends only on its release
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            lockout_r <= 1'b0;
        end else if (!ren) begin
            lockout_r <= 1'b0;
        end else if (cmd_stb && rx == CMD_LLO) begin
            lockout_r <= 1'b1;
        end
    end

    // Remote: entered when listen-addressed under remote enable, left on go to local
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            remote_r <= 1'b0;
        end else if (!ren || gtl_hit) begin
            remote_r <= 1'b0;
        end else if (cmd_stb && grp_listen && adr_me) begin
            remote_r <= 1'b1;
        end
    end

    // Panel keys masked while locked out; power switch never passes here
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            panel_keys_out <= 16'h0000;
        end else begin
            panel_keys_out <= lockout_r ? 16'h0000 : panel_keys_in;
        end
    end

    // ************************************************************
    // Status byte and data
    // ************************************************************
    // Status byte from the scan engine, zero from power-up
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            status_r <= STATUS_DEF;
        end else if (status_wr_in) begin
            status_r <= status_in;
        end
    end

    // Drive status byte while polled, talk-addressed and attention released
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            drive_r <= 1'b0;
            link.dev_dio_n <= 8'hFF;
        end else begin
            drive_r <= spoll_r & talk_r & ~atn;
            link.dev_dio_n <= ~status_r;
        end
    end

    // Attention cuts the drive at once, so a command byte never meets the status byte
    assign link.dev_dio_oe = drive_r & ~atn;

    // Data bytes pass on only when listen-addressed
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ddc_valid_out <= 1'b0;
            ddc_byte_out <= 8'h00;
        end else begin
            ddc_valid_out <= dat_stb & listen_r;
            ddc_byte_out <= dat_stb ? rx : ddc_byte_out;
        end
    end

    // ************************************************************
    // Default state
    // ************************************************************
    // Clear pulse erases program memory and opens all channels
    always_ff @(posedge clk_in) begin
        clear_out <= rst_in | clr;
    end

    // Default configuration; reset and clears load the same values
    always_ff @(posedge clk_in) begin
        if (rst_in || clr) begin
            buf_ptr_out <= PTR_FIRST;
            disp_ptr_out <= PTR_FIRST;
            prog_mode_out <= PROG_STEP;
            trig_mode_out <= TRIG_DEF;
            io_port_out <= IO_PORT_DEF;
            alarm_time_out <= ALARM_DEF;
            alarm_en_out <= 1'b0;
            interval_out <= INTERVAL_DEF_MS;
            settle_out <= SETTLE_DEF_MS;
            eoi_en_out <= EOI_DEF;
            srq_en_out <= SRQ_DEF;
            prefix_out <= PREFIX_DEF;
        end else if (mode_wr_in) begin
            prog_mode_out <= prog_mode_in;
            trig_mode_out <= trig_mode_in;
        end
    end

    // Program run state and start/stop indicator
    always_ff @(posedge clk_in) begin
        if (rst_in || clr) begin
            run_out <= 1'b0;
        end else if (get_hit && trig_mode_out == START_ON_TRIGGER_MODE) begin
            run_out <= 1'b1;
        end else if (get_hit && trig_mode_out == STOP_ON_TRIGGER_MODE) begin
            run_out <= 1'b0;
        end
    end

    // Plain state outputs
    assign lockout_out = lockout_r;
    assign remote_out = remote_r;
    assign talk_out = talk_r;
    assign listen_out = listen_r;
    assign spoll_out = spoll_r;
endmodule

// ===== verilog/gpib_bus_controller.sv
// Controller end: runs bus sequences ordered over an Avalon-MM slave
`timescale 1ns/1ps
module gpib_bus_controller
    import gpib_resp_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Avalon-MM slave
    input wire logic [3:0] avs_address_in,
    input wire logic avs_write_in,
    input wire logic avs_read_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // Bus side
    gpib_link_if.ctl link
);
    // ************************************************************
    // State
    // ************************************************************
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ISSUE = 4'b0010,
        ST_WAIT = 4'b0100,
        ST_GAP = 4'b1000
    } ctl_state_e;
    ctl_state_e state_r;
    logic [9:0] step_r [4]; // Steps: kind and byte
    logic [1:0] last_r; // Index of last step
    logic [1:0] idx_r; // Current step
    logic [1:0] wait_r; // Poll settle count
    logic [7:0] poll_byte_r;
    logic poll_valid_r;
    logic ren_r;
    logic rd_done_r;
    logic [1:0] reg_sel;
    logic cmd_wr; // Accepted order
    logic [2:0] op;
    logic [4:0] adr;
    logic [7:0] obyte;
    logic [1:0] kind;

    assign reg_sel = avs_address_in[3:2];
    assign op = avs_writedata_in[F_OP_LSB +: 3];
    assign adr = avs_writedata_in[F_ADDR_LSB +: 5];
    assign obyte = avs_writedata_in[F_BYTE_LSB +: 8];
    assign cmd_wr = avs_write_in & (reg_sel == REG_CMD) & (state_r == ST_IDLE);
    assign kind = step_r[idx_r][9:8];
    // Orders stall while busy; reads take one extra cycle
    assign avs_waitrequest_out = (avs_write_in & (reg_sel == REG_CMD) & (state_r != ST_IDLE))
                               | (avs_read_in & ~rd_done_r);

    // ************************************************************
    // Order decode into steps
    // ************************************************************
    // Build the step list; address and data orders listen-address first, polls talk-address after poll enable
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            for (int i = 0; i < 4; i++) begin
                step_r[i] <= 10'h000;
            end
            last_r <= 2'h0;
        end else if (cmd_wr) begin
            unique case (op)
                OP_ADDR: begin
                    step_r[0] <= {K_CMD, 3'h1, adr};
                    step_r[1] <= {K_CMD, obyte};
                    last_r <= 2'h1;
                end
                OP_DATA: begin
                    step_r[0] <= {K_CMD, 3'h1, adr};
                    step_r[1] <= {K_DATA, obyte};
                    last_r <= 2'h1;
                end
                OP_POLL: begin
                    step_r[0] <= {K_CMD, CMD_SPE};
                    step_r[1] <= {K_CMD, 3'h2, adr};
                    step_r[2] <= {K_READ, 8'h00};
                    step_r[3] <= {K_CMD, CMD_SPD};
                    last_r <= 2'h3;
                end
                default: begin
                    step_r[0] <= {K_CMD, obyte};
                    last_r <= 2'h0;
                end
            endcase
        end
    end

    // Remote enable line
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ren_r <= 1'b0;
        end else if (avs_write_in && reg_sel == REG_CMD && state_r == ST_IDLE) begin
            if (op == OP_REN_ON) begin
                ren_r <= 1'b1;
            end else if (op == OP_REN_OFF) begin
                ren_r <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    // Issue each step, wait on reads, one gap cycle between steps
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_r <= ST_IDLE;
            idx_r <= 2'h0;
            wait_r <= 2'h0;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    idx_r <= 2'h0;
                    if (cmd_wr && op != OP_REN_ON && op != OP_REN_OFF) begin
                        state_r <= ST_ISSUE;
                    end
                end
                ST_ISSUE: begin
                    wait_r <= POLL_WAIT;
                    state_r <= (kind == K_READ) ? ST_WAIT : ST_GAP;
                end
                ST_WAIT: begin
                    wait_r <= wait_r - 2'h1;
                    if (wait_r == 2'h0) begin
                        state_r <= ST_GAP;
                    end
                end
                ST_GAP: begin
                    idx_r <= idx_r + 2'h1;
                    state_r <= (idx_r == last_r) ? ST_IDLE : ST_ISSUE;
                end
            endcase
        end
    end

    // Bus lines: attention low for commands, released for data and reads
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            link.atn_n <= 1'b1;
            link.stb <= 1'b0;
            link.ctl_dio_n <= 8'hFF;
            link.ctl_dio_oe <= 1'b0;
        end else begin
            link.stb <= (state_r == ST_ISSUE) & (kind != K_READ);
            if (state_r == ST_ISSUE) begin
                link.atn_n <= (kind != K_CMD);
                link.ctl_dio_n <= ~step_r[idx_r][7:0];
                link.ctl_dio_oe <= (kind != K_READ);
            end else if (state_r == ST_GAP) begin
                link.ctl_dio_oe <= 1'b0;
            end
        end
    end

    assign link.ren_n = ~ren_r;

    // Status byte taken at the end of the read wait
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            poll_byte_r <= 8'h00;
            poll_valid_r <= 1'b0;
        end else if (state_r == ST_WAIT && wait_r == 2'h0) begin
            poll_byte_r <= ~link.dio_n;
            poll_valid_r <= 1'b1;
        end else if (cmd_wr && op == OP_POLL) begin
            poll_valid_r <= 1'b0;
        end
    end

    // ************************************************************
    // Register reads
    // ************************************************************
    // Read data registered; unmapped reads give zero
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rd_done_r <= 1'b0;
            avs_readdata_out <= 32'h00000000;
        end else begin
            rd_done_r <= avs_read_in & ~rd_done_r;
            if (avs_read_in && !rd_done_r) begin
                avs_readdata_out <= (reg_sel == REG_STAT)
                    ? {21'h000000, poll_valid_r, ren_r, state_r != ST_IDLE, poll_byte_r}
                    : 32'h00000000;
            end
        end
    end
endmodule

// ===== test/gpib_resp_asserts.sv
// Wire-level checks on the link between controller and responder
`timescale 1ns/1ps
module gpib_resp_asserts
    import gpib_resp_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_in,
    // Bus wires
    input wire logic atn_n,
    input wire logic stb,
    input wire logic [7:0] dio_n,
    input wire logic ctl_dio_oe,
    input wire logic dev_dio_oe,
    input wire logic [7:0] dev_dio_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst_in);
    // ************************************************************
    // Assertions
    // ************************************************************
    poll_drive_a: assert property ($rose(dev_dio_oe) |-> atn_n && $past(atn_n))
        else $error("responder drove data under attention");
    poll_end_a: assert property ($fell(atn_n) |=> !dev_dio_oe)
        else $error("responder still drove after attention");
    no_clash_a: assert property (!(ctl_dio_oe && dev_dio_oe))
        else $error("both ends drive data");
    strobe_pulse_a: assert property (stb |=> !stb)
        else $error("byte strobe longer than one cycle");
    strobe_drive_a: assert property (stb |-> ctl_dio_oe)
        else $error("strobe without controller data");
    spe_talk_a: assert property (stb && !atn_n && dio_n == ~CMD_SPE |->
        ##[1:4] stb && !atn_n && dio_n[6:5] == ~GRP_TALK)
        else $error("no talk address after poll enable");
    byte_hold_a: assert property (dev_dio_oe && $past(dev_dio_oe) |-> $stable(dev_dio_n))
        else $error("status byte changed while presented");
    poll_close_a: assert property ($rose(dev_dio_oe) |-> ##[2:6] $fell(atn_n))
        else $error("poll not closed in time");
    // Main scenarios seen
    cover property ($rose(dev_dio_oe));
    cover property (stb && atn_n);
    cover property (stb && !atn_n && dio_n == ~CMD_DCL);
endmodule

// ===== test/gpib_bus_command_responder_tb.sv
// Self-checking bench for the controller and responder pair
`timescale 1ns/1ps
module gpib_bus_command_responder_tb import gpib_resp_pkg::*;;
    logic clk_in = 0;
    logic rst_in = 1;
    // Avalon master side
    logic [3:0] adr = 0;
    logic wr = 0, rd = 0;
    logic [31:0] wd = 0, rdat, last;
    logic wreq;
    // Responder inputs and outputs
    logic [4:0] my_addr = 0;
    logic st_wr = 0, md_wr = 0;
    logic [7:0] st = 0, s, dby, db, bp, dp;
    logic [1:0] pm = 0, pmo;
    logic [2:0] tm = 0, tmo;
    logic [15:0] keys = 0, keys_o, sd;
    logic lock, rem, talk, lis, spl, dv, clr, aen, eoi, srq, run;
    logic [3:0] io;
    logic [23:0] al;
    logic [16:0] iv;
    logic [4:0] pf;
    // Model state and results seen
    int fails = 0, checks = 0, clears = 0, e_clr = 1, e_lis = 0, e_talk = 0, e_lock = 0;
    logic [7:0] q[$], dq[$];
    initial forever #12.5 clk_in = ~clk_in;
    gpib_link_if gpib_link_if_inst (.clk(clk_in));
    gpib_bus_controller gpib_bus_controller_inst (.clk_in(clk_in), .rst_in(rst_in),
        .avs_address_in(adr), .avs_write_in(wr), .avs_read_in(rd), .avs_writedata_in(wd),
        .avs_readdata_out(rdat), .avs_waitrequest_out(wreq), .link(gpib_link_if_inst));
    gpib_bus_command_responder gpib_bus_command_responder_inst (.clk_in(clk_in),
        .rst_in(rst_in), .link(gpib_link_if_inst), .my_addr_in(my_addr), .status_wr_in(st_wr),
        .status_in(st), .mode_wr_in(md_wr), .prog_mode_in(pm), .trig_mode_in(tm),
        .panel_keys_in(keys), .panel_keys_out(keys_o), .lockout_out(lock), .remote_out(rem),
        .talk_out(talk), .listen_out(lis), .spoll_out(spl), .ddc_valid_out(dv),
        .ddc_byte_out(db), .clear_out(clr), .buf_ptr_out(bp), .disp_ptr_out(dp),
        .prog_mode_out(pmo), .trig_mode_out(tmo), .io_port_out(io), .alarm_time_out(al),
        .alarm_en_out(aen), .interval_out(iv), .settle_out(sd), .eoi_en_out(eoi),
        .srq_en_out(srq), .prefix_out(pf), .run_out(run));
    gpib_resp_asserts gpib_resp_asserts_inst (.clk(clk_in), .rst_in(rst_in),
        .atn_n(gpib_link_if_inst.atn_n), .stb(gpib_link_if_inst.stb),
        .dio_n(gpib_link_if_inst.dio_n), .ctl_dio_oe(gpib_link_if_inst.ctl_dio_oe),
        .dev_dio_oe(gpib_link_if_inst.dev_dio_oe), .dev_dio_n(gpib_link_if_inst.dev_dio_n));
    // Count clear pulses and collect data bytes handed on
    always @(posedge clk_in) begin
        if (!rst_in && clr === 1'b1) clears++;
        if (dv === 1'b1) q.push_back(db);
    end
    // Verdict and end of run
    task end_sim;
        if (fails == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task chk(string n, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s exp %h seen %h", n, exp, seen);
        end
    endtask
    // One Avalon transfer, held until waitrequest is seen low
    task av(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge clk_in);
        wr <= w;
        rd <= !w;
        adr <= a;
        wd <= d;
        for (n = 0; n < 60; n++) begin
            @(posedge clk_in);
            if (wreq === 1'b0) break;
        end
        if (n == 60) begin
            fails++;
            end_sim;
        end
        r = rdat;
        wr <= 0;
        rd <= 0;
    endtask
    // Order a bus sequence and wait until the controller is idle
    task op(input logic [2:0] o, input logic [4:0] a, input logic [7:0] b);
        int n;
        av(1, 4'h0, {16'h0000, o, a, b}, last);
        for (n = 0; n < 60; n++) begin
            av(0, 4'h4, 32'h0, last);
            if (last[8] === 1'b0) break;
        end
        if (n == 60) begin
            fails++;
            end_sim;
        end
    endtask
    task mode(input logic [1:0] p, input logic [2:0] t);
        @(posedge clk_in);
        pm <= p;
        tm <= t;
        md_wr <= 1;
        @(posedge clk_in);
        md_wr <= 0;
    endtask
    task chk_def;
        chk("prog", pmo, PROG_STEP);
        chk("io", io, IO_PORT_DEF);
        chk("alarm", {aen, al}, {1'b0, ALARM_DEF});
        chk("intv", iv, INTERVAL_DEF_MS);
        chk("settle", sd, SETTLE_DEF_MS);
        chk("eoisrq", {eoi, srq}, {EOI_DEF, SRQ_DEF});
        chk("prefix", pf, PREFIX_DEF);
        chk("ptrs", {bp, dp}, {PTR_FIRST, PTR_FIRST});
        chk("trig", tmo, TRIG_DEF);
        chk("clears", clears, e_clr);
    endtask
    task chk_state;
        chk("listen", lis, e_lis);
        chk("talk", talk, e_talk);
        chk("lock", lock, e_lock);
        while (q.size() > 0 && dq.size() > 0) chk("ddc", q.pop_front(), dq.pop_front());
        chk("ddcn", q.size(), dq.size());
    endtask
    // Main sequence
    initial begin
        void'($urandom(64));
        my_addr <= 5'($urandom % 30);
        repeat (6) @(posedge clk_in);
        rst_in <= 0;
        repeat (3) @(posedge clk_in);
        chk_def();
        op(OP_POLL, my_addr, 8'h00);
        e_talk = 1;
        chk("poll", last[10:0], {3'h4, STATUS_DEF});
        chk("spoll", spl, 1'b0);
        s = 8'($urandom);
        @(posedge clk_in);
        st <= s;
        st_wr <= 1;
        @(posedge clk_in);
        st_wr <= 0;
        op(OP_POLL, my_addr, 8'h00);
        chk("poll2", last[7:0], s);
        chk_state();
        op(OP_CMD, 5'h00, CMD_UNT);
        e_talk = 0;
        mode(CONTINUOUS_PROGRAM_MODE, START_ON_TRIGGER_MODE);
        op(OP_ADDR, my_addr ^ 5'h01, CMD_SDC);
        op(OP_ADDR, my_addr ^ 5'h01, CMD_GET);
        chk("nomatch", {pmo, run}, {CONTINUOUS_PROGRAM_MODE, 1'b0});
        chk_state();
        op(OP_ADDR, my_addr, CMD_GET);
        e_lis = 1;
        chk("run", run, 1'b1);
        mode(CONTINUOUS_PROGRAM_MODE, STOP_ON_TRIGGER_MODE);
        op(OP_ADDR, my_addr, CMD_GET);
        chk("stop", run, 1'b0);
        dby = 8'($urandom);
        op(OP_DATA, 5'h00, dby);
        dq.push_back(dby);
        chk_state();
        op(OP_CMD, 5'h00, CMD_UNL);
        e_lis = 0;
        op(OP_DATA, my_addr ^ 5'h01, ~dby);
        chk_state();
        keys <= 16'($urandom);
        op(OP_CMD, 5'h00, CMD_LLO);
        chk_state();
        chk("keys", keys_o, keys);
        op(OP_REN_ON, 5'h00, 8'h00);
        op(OP_ADDR, my_addr, CMD_LLO);
        e_lock = 1;
        e_lis = 1;
        chk_state();
        chk("keys_lock", keys_o, 16'h0000);
        chk("remote", rem, 1'b1);
        op(OP_ADDR, my_addr, CMD_GTL);
        chk("gtl", {rem, lock}, 2'b01);
        op(OP_REN_OFF, 5'h00, 8'h00);
        e_lock = 0;
        chk_state();
        chk("keys_back", keys_o, keys);
        chk("rem_off", rem, 1'b0);
        for (int i = 0; i < 2; i++) begin
            mode(CONTINUOUS_PROGRAM_MODE, START_ON_TRIGGER_MODE);
            op(i ? OP_ADDR : OP_CMD, my_addr, i ? CMD_SDC : CMD_DCL);
            e_clr++;
            chk_def();
            chk_state();
        end
        end_sim();
    end
endmodule
